// file: verilog/universal_serial_unit.sv
// The APB slave port and the placing of the registers were decided locally.
`include "usi_map.svh"

module universal_serial_unit
  import usi_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // system side
  input wire logic i_timer0_match,
  input wire logic i_global_irq_enable,
  output logic o_start_irq,
  output logic o_overflow_irq,
  // data output pin
  output logic o_do_pin_out,
  output logic o_do_pin_oe_n,
  // data input / serial data pin
  input wire logic i_sda_pin_in,
  output logic o_sda_pin_out,
  output logic o_sda_pin_oe_n,
  output logic o_sda_pullup,
  // serial clock pin
  input wire logic i_clk_pin_in,
  output logic o_clk_pin_out,
  output logic o_clk_pin_oe_n,
  output logic o_clk_pullup
);

  // ****************************************************************
  // address decode
  // ****************************************************************
  function automatic logic reg_hit(input logic [11:0] addr,
                                   input logic [11:0] off);
    reg_hit = (addr == off);
  endfunction

  logic pready_reg;
  logic acc;
  logic wr_en;
  logic st_wr;
  logic cr_wr;
  logic dr_wr;
  logic pt_wr;
  logic mapped;

  assign acc = i_psel & i_penable;
  assign wr_en = acc & pready_reg & i_pwrite;
  assign st_wr = wr_en & reg_hit(i_paddr, `USI_OFF_STATUS);
  assign cr_wr = wr_en & reg_hit(i_paddr, `USI_OFF_CTRL);
  assign dr_wr = wr_en & reg_hit(i_paddr, `USI_OFF_DATA);
  assign pt_wr = wr_en & reg_hit(i_paddr, `USI_OFF_PORT);
  assign mapped = reg_hit(i_paddr, `USI_OFF_STATUS) |
                  reg_hit(i_paddr, `USI_OFF_CTRL) |
                  reg_hit(i_paddr, `USI_OFF_DATA) |
                  reg_hit(i_paddr, `USI_OFF_PORT);

  // ****************************************************************
  // pin synchronisers and edge detect
  // ****************************************************************
  logic sda_meta_reg;
  logic sda_sync_reg;
  logic sda_prev_reg;
  logic clk_meta_reg;
  logic clk_sync_reg;
  logic clk_prev_reg;

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      clk_meta_reg <= 1'b1;
      clk_sync_reg <= 1'b1;
      clk_prev_reg <= 1'b1;
    end else begin
      sda_meta_reg <= i_sda_pin_in;
      sda_sync_reg <= sda_meta_reg;
      sda_prev_reg <= sda_sync_reg;
      clk_meta_reg <= i_clk_pin_in;
      clk_sync_reg <= clk_meta_reg;
      clk_prev_reg <= clk_sync_reg;
    end
  end

  logic clk_rise;
  logic clk_fall;
  logic start_det;
  logic stop_det;

  assign clk_rise = clk_sync_reg & ~clk_prev_reg;
  assign clk_fall = ~clk_sync_reg & clk_prev_reg;
  // data edge while clock high marks start (fall) or stop (rise)
  assign start_det = clk_sync_reg & clk_prev_reg & sda_prev_reg &
                     ~sda_sync_reg;
  assign stop_det = clk_sync_reg & clk_prev_reg & ~sda_prev_reg &
                    sda_sync_reg;

  // ****************************************************************
  // control register
  // ****************************************************************
  logic start_ie_reg;
  logic ovf_ie_reg;
  wire_mode_t wire_mode_reg;
  clk_src_t clk_src_reg;
  logic clk_sel_reg;

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      start_ie_reg <= 1'b0;
      ovf_ie_reg <= 1'b0;
      wire_mode_reg <= WM_OFF;
      clk_src_reg <= CS_SOFT;
      clk_sel_reg <= 1'b0;
    end else if (cr_wr) begin
      start_ie_reg <= i_pwdata[`USI_CR_START_IE];
      ovf_ie_reg <= i_pwdata[`USI_CR_OVF_IE];
      wire_mode_reg <= wire_mode_t'(i_pwdata[`USI_CR_WM_HI:`USI_CR_WM_LO]);
      clk_src_reg <= clk_src_t'(i_pwdata[`USI_CR_CS_HI:`USI_CR_CS_LO]);
      clk_sel_reg <= i_pwdata[`USI_CR_CLK_STB];
    end
  end

  // ****************************************************************
  // clock source selection
  // ****************************************************************
  logic two_wire;
  logic soft_stb;
  logic tgl_stb;
  logic shift_clk;
  logic cnt_clk;
  clk_src_t cur_src;
  logic cur_sel;

  assign two_wire = wire_mode_reg[1];
  // strobes act on the values carried by the same write
  assign cur_src = cr_wr ?
                   clk_src_t'(i_pwdata[`USI_CR_CS_HI:`USI_CR_CS_LO]) :
                   clk_src_reg;
  assign cur_sel = cr_wr ? i_pwdata[`USI_CR_CLK_STB] : clk_sel_reg;
  assign soft_stb = cr_wr & i_pwdata[`USI_CR_CLK_STB];
  assign tgl_stb = cr_wr & i_pwdata[`USI_CR_TGL_STB];

  always_comb begin
    shift_clk = 1'b0;
    cnt_clk = 1'b0;
    case (cur_src)
      CS_SOFT: begin
        shift_clk = soft_stb;
        cnt_clk = soft_stb;
      end
      CS_TIMER: begin
        shift_clk = i_timer0_match;
        cnt_clk = i_timer0_match;
      end
      CS_EXT_POS: begin
        shift_clk = clk_rise;
        cnt_clk = cur_sel ? tgl_stb : (clk_rise | clk_fall);
      end
      CS_EXT_NEG: begin
        shift_clk = clk_fall;
        cnt_clk = cur_sel ? tgl_stb : (clk_rise | clk_fall);
      end
      default: begin
        shift_clk = 1'b0;
        cnt_clk = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // shift register and output latch
  // ****************************************************************
  logic [7:0] shift_reg;
  logic do_latch_reg;
  logic msb_out;

  // a write in the same cycle as a shift wins, no shift done
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      shift_reg <= `USI_RST_BYTE;
    end else if (dr_wr) begin
      shift_reg <= i_pwdata[7:0];
    end else if (shift_clk) begin
      shift_reg <= {shift_reg[6:0], sda_sync_reg};
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      do_latch_reg <= 1'b0;
    end else if (clk_src_reg == CS_EXT_POS ? clk_fall : clk_rise) begin
      do_latch_reg <= shift_reg[7];
    end
  end

  assign msb_out = clk_src_reg[1] ? do_latch_reg : shift_reg[7];

  // ****************************************************************
  // transfer counter
  // ****************************************************************
  logic [3:0] cnt_reg;
  logic wrap;

  assign wrap = cnt_clk & (cnt_reg == `USI_CNT_MAX) & ~st_wr;

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_reg <= `USI_RST_CNT;
    end else if (st_wr) begin
      cnt_reg <= i_pwdata[`USI_ST_CNT_HI:`USI_ST_CNT_LO];
    end else if (cnt_clk) begin
      cnt_reg <= cnt_reg + `USI_CNT_ONE;
    end
  end

  // ****************************************************************
  // status flags, set wins over write-one clear except overflow, whose wrap set is blocked by any status write
  // ****************************************************************
  logic start_flag_reg;
  logic ovf_flag_reg;
  logic stop_flag_reg;
  logic start_set;

  assign start_set = two_wire ? start_det : cnt_clk;

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      start_flag_reg <= 1'b0;
    end else if (start_set) begin
      start_flag_reg <= 1'b1;
    end else if (st_wr & i_pwdata[`USI_ST_START]) begin
      start_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ovf_flag_reg <= 1'b0;
    end else if (wrap) begin
      ovf_flag_reg <= 1'b1;
    end else if (st_wr & i_pwdata[`USI_ST_OVF]) begin
      ovf_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      stop_flag_reg <= 1'b0;
    end else if (two_wire & stop_det) begin
      stop_flag_reg <= 1'b1;
    end else if (st_wr & i_pwdata[`USI_ST_STOP]) begin
      stop_flag_reg <= 1'b0;
    end
  end

  assign o_start_irq = start_flag_reg & start_ie_reg &
                       i_global_irq_enable;
  assign o_overflow_irq = ovf_flag_reg & ovf_ie_reg &
                          i_global_irq_enable;

  // ****************************************************************
  // port and direction register
  // ****************************************************************
  logic [7:0] port_reg;

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      port_reg <= `USI_RST_BYTE;
    end else if (pt_wr) begin
      port_reg <= i_pwdata[7:0];
    end else if (tgl_stb) begin
      port_reg[`USI_PT_CLK] <= ~port_reg[`USI_PT_CLK];
    end
  end

  // ****************************************************************
  // pin drivers
  // ****************************************************************
  logic p_do;
  logic p_sda;
  logic p_clk;
  logic d_do;
  logic d_sda;
  logic d_clk;
  logic clk_hold;

  assign p_do = port_reg[`USI_PT_DO];
  assign p_sda = port_reg[`USI_PT_SDA];
  assign p_clk = port_reg[`USI_PT_CLK];
  assign d_do = port_reg[`USI_PT_DIR_DO];
  assign d_sda = port_reg[`USI_PT_DIR_SDA];
  assign d_clk = port_reg[`USI_PT_DIR_CLK];
  assign clk_hold = start_flag_reg |
                    ((wire_mode_reg == WM_TWO_HOLD) & ovf_flag_reg);

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_do_pin_out <= 1'b0;
      o_do_pin_oe_n <= 1'b1;
      o_sda_pin_out <= 1'b0;
      o_sda_pin_oe_n <= 1'b1;
      o_sda_pullup <= 1'b0;
      o_clk_pin_out <= 1'b0;
      o_clk_pin_oe_n <= 1'b1;
      o_clk_pullup <= 1'b0;
    end else begin
      // plain port behaviour unless a mode overrides it
      o_do_pin_out <= (wire_mode_reg == WM_THREE) ? msb_out : p_do;
      o_do_pin_oe_n <= ~d_do;
      if (two_wire) begin
        o_sda_pin_out <= 1'b0;
        o_sda_pin_oe_n <= ~(d_sda & (~msb_out | ~p_sda));
        o_sda_pullup <= 1'b0;
        o_clk_pin_out <= 1'b0;
        o_clk_pin_oe_n <= ~(d_clk & (~p_clk | clk_hold));
        o_clk_pullup <= 1'b0;
      end else begin
        o_sda_pin_out <= p_sda;
        o_sda_pin_oe_n <= ~d_sda;
        o_sda_pullup <= ~d_sda & p_sda;
        o_clk_pin_out <= p_clk;
        o_clk_pin_oe_n <= ~d_clk;
        o_clk_pullup <= ~d_clk & p_clk;
      end
    end
  end

  // ****************************************************************
  // apb read path, one wait state
  // ****************************************************************
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pready_reg <= 1'b0;
      o_prdata <= `USI_RDATA_ZERO;
      o_pslverr <= 1'b0;
    end else if (acc & ~pready_reg) begin
      pready_reg <= 1'b1;
      o_pslverr <= ~mapped;
      o_prdata <= `USI_RDATA_ZERO;
      if (reg_hit(i_paddr, `USI_OFF_STATUS)) begin
        o_prdata[7:0] <= {start_flag_reg, ovf_flag_reg, stop_flag_reg,
                          two_wire & (shift_reg[7] != sda_sync_reg),
                          cnt_reg};
      end else if (reg_hit(i_paddr, `USI_OFF_CTRL)) begin
        o_prdata[7:0] <= {start_ie_reg, ovf_ie_reg, wire_mode_reg,
                          clk_src_reg, 2'b00};
      end else if (reg_hit(i_paddr, `USI_OFF_DATA)) begin
        o_prdata[7:0] <= shift_reg;
      end else if (reg_hit(i_paddr, `USI_OFF_PORT)) begin
        o_prdata[7:0] <= port_reg;
      end
    end else begin
      pready_reg <= 1'b0;
      o_pslverr <= 1'b0;
    end
  end

  assign o_pready = pready_reg;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);

  cnt_step_a: assert property (
    cnt_clk & ~st_wr |=> cnt_reg == $past(cnt_reg) + `USI_CNT_ONE)
    else $error("counter did not step");

  ext_count_a: assert property (
    (wire_mode_reg == WM_OFF) & clk_src_reg[1] & ~clk_sel_reg &
    (clk_rise | clk_fall) & ~st_wr & ~cr_wr |=> cnt_reg != $past(cnt_reg))
    else $error("external edge ignored with outputs off");

  start_irq_a: assert property (
    start_flag_reg & start_ie_reg & i_global_irq_enable |-> o_start_irq)
    else $error("start request not raised");

  ovf_irq_a: assert property (
    o_overflow_irq |-> ovf_flag_reg & ovf_ie_reg)
    else $error("overflow request without cause");

  sda_pull_a: assert property (
    two_wire & d_sda & ~msb_out |=> !o_sda_pin_oe_n & !o_sda_pin_out)
    else $error("data line not pulled low");

  pullup_off_a: assert property (
    two_wire |=> !o_sda_pullup && !o_clk_pullup)
    else $error("pull-up left on in two-wire");

  ovf_hold_a: assert property (
    (wire_mode_reg == WM_TWO_HOLD) & ovf_flag_reg & d_clk
    |=> !o_clk_pin_oe_n)
    else $error("clock not held on overflow");

  ovf_wrap_a: assert property (
    wrap |=> ovf_flag_reg && cnt_reg == `USI_RST_CNT)
    else $error("wrap did not set overflow");

  strobe_zero_a: assert property (
    acc & ~pready_reg & reg_hit(i_paddr, `USI_OFF_CTRL)
    |=> o_prdata[1:0] == 2'b00)
    else $error("strobe bits read nonzero");

  clk_toggle_a: assert property (
    tgl_stb & ~pt_wr |=> port_reg[`USI_PT_CLK] != $past(p_clk))
    else $error("toggle strobe missed");

endmodule

// file: verilog/usi_map.svh
`ifndef USI_MAP_SVH
`define USI_MAP_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define USI_OFF_STATUS 12'h000
`define USI_OFF_CTRL 12'h004
`define USI_OFF_DATA 12'h008
`define USI_OFF_PORT 12'h00c

// ****************************************************************
// status fields
// ****************************************************************
`define USI_ST_START 7
`define USI_ST_OVF 6
`define USI_ST_STOP 5
`define USI_ST_COLL 4
`define USI_ST_CNT_HI 3
`define USI_ST_CNT_LO 0

// ****************************************************************
// control fields
// ****************************************************************
`define USI_CR_START_IE 7
`define USI_CR_OVF_IE 6
`define USI_CR_WM_HI 5
`define USI_CR_WM_LO 4
`define USI_CR_CS_HI 3
`define USI_CR_CS_LO 2
`define USI_CR_CLK_STB 1
`define USI_CR_TGL_STB 0

// ****************************************************************
// port / direction fields
// ****************************************************************
`define USI_PT_DO 0
`define USI_PT_SDA 1
`define USI_PT_CLK 2
`define USI_PT_DIR_DO 4
`define USI_PT_DIR_SDA 5
`define USI_PT_DIR_CLK 6

// ****************************************************************
// reset values and constants
// ****************************************************************
`define USI_RST_BYTE 8'h00
`define USI_RST_CNT 4'h0
`define USI_CNT_MAX 4'hf
`define USI_CNT_ONE 4'h1
`define USI_RDATA_ZERO 32'h0000_0000

`endif

// file: verilog/usi_pkg.sv
package usi_pkg;

  typedef enum logic [1:0] {
    WM_OFF = 2'b00,
    WM_THREE = 2'b01,
    WM_TWO = 2'b10,
    WM_TWO_HOLD = 2'b11
  } wire_mode_t;

  typedef enum logic [1:0] {
    CS_SOFT = 2'b00,
    CS_TIMER = 2'b01,
    CS_EXT_POS = 2'b10,
    CS_EXT_NEG = 2'b11
  } clk_src_t;

endpackage

// file: dv/serial_peer.sv
module serial_peer (
  // unit pin drivers
  input wire logic i_clk_out,
  input wire logic i_clk_oe_n,
  input wire logic i_sda_out,
  input wire logic i_sda_oe_n,
  // resolved wire levels
  output logic o_clk_wire,
  output logic o_sda_wire
);
  timeunit 1ns;
  timeprecision 1ns;

  logic clk_drv = 1'b1;
  logic sda_drv = 1'b1;

  // wired-and: a released line rests high on its pull-up
  assign o_clk_wire = clk_drv & (i_clk_oe_n | i_clk_out);
  assign o_sda_wire = sda_drv & (i_sda_oe_n | i_sda_out);

  // byte msb first; data moves while the clock is low
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      clk_drv = 1'b0;
      sda_drv = b[i];
      #80;
      clk_drv = 1'b1;
      #80;
    end
    sda_drv = 1'b1;
  endtask

  // data falls while the clock stands high
  task automatic start_cond();
    sda_drv = 1'b0;
    #160;
  endtask
endmodule

// file: dv/universal_serial_unit_tb.sv
`include "usi_map.svh"

module universal_serial_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic i_core_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0000_0000;
  logic i_timer0_match = 1'b0, i_global_irq_enable = 1'b1;
  logic [31:0] o_prdata;
  logic o_pready, o_pslverr, o_start_irq, o_overflow_irq;
  logic o_do_pin_out, o_do_pin_oe_n, o_sda_pin_out, o_sda_pin_oe_n;
  logic o_sda_pullup, o_clk_pin_out, o_clk_pin_oe_n, o_clk_pullup;
  logic i_sda_pin_in, i_clk_pin_in;
  int err_total = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [31:0] rdata;
  logic rerr;

  always #10 i_core_clk = ~i_core_clk;

  universal_serial_unit universal_serial_unit_inst (
    .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_timer0_match(i_timer0_match),
    .i_global_irq_enable(i_global_irq_enable), .o_start_irq(o_start_irq),
    .o_overflow_irq(o_overflow_irq), .o_do_pin_out(o_do_pin_out),
    .o_do_pin_oe_n(o_do_pin_oe_n), .i_sda_pin_in(i_sda_pin_in),
    .o_sda_pin_out(o_sda_pin_out), .o_sda_pin_oe_n(o_sda_pin_oe_n),
    .o_sda_pullup(o_sda_pullup), .i_clk_pin_in(i_clk_pin_in),
    .o_clk_pin_out(o_clk_pin_out), .o_clk_pin_oe_n(o_clk_pin_oe_n),
    .o_clk_pullup(o_clk_pullup));

  serial_peer serial_peer_inst (
    .i_clk_out(o_clk_pin_out), .i_clk_oe_n(o_clk_pin_oe_n),
    .i_sda_out(o_sda_pin_out), .i_sda_oe_n(o_sda_pin_oe_n),
    .o_clk_wire(i_clk_pin_in), .o_sda_wire(i_sda_pin_in));

  // ****************************************************************
  // report and helpers
  // ****************************************************************
  task automatic end_of_test();
    $display("errors %0d, compares %0d", err_total, n_compared);
    if (err_total == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic pin(input logic got, input logic exp);
    cmp({31'h0, got}, {31'h0, exp});
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [7:0] d);
    @(posedge i_core_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= {24'h0, d};
    @(posedge i_core_clk);
    i_penable <= 1'b1;
    do @(posedge i_core_clk); while (o_pready !== 1'b1);
    rdata = o_prdata;
    rerr = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask

  task automatic w(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    cmp(rdata, {24'h0, exp});
  endtask

  task automatic settle();
    repeat (4) @(posedge i_core_clk);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    rd(`USI_OFF_STATUS, 8'h00);
    rd(`USI_OFF_CTRL, 8'h00);
    pin(o_clk_pin_oe_n, 1'b1);
    pin(o_do_pin_oe_n, 1'b1);
    rd(12'h010, 8'h00);
    pin(rerr, 1'b1);
  endtask

  task automatic t_count();
    w(`USI_OFF_STATUS, 8'h09);
    settle();
    rd(`USI_OFF_STATUS, 8'h09);
    w(`USI_OFF_CTRL, 8'h02);
    rd(`USI_OFF_STATUS, 8'h8a);
    rd(`USI_OFF_CTRL, 8'h00);
    w(`USI_OFF_CTRL, 8'h80);
    settle();
    pin(o_start_irq, 1'b1);
    i_global_irq_enable <= 1'b0;
    settle();
    pin(o_start_irq, 1'b0);
    i_global_irq_enable <= 1'b1;
  endtask

  task automatic t_ovf();
    w(`USI_OFF_STATUS, 8'hcf);
    w(`USI_OFF_CTRL, 8'h42);
    rd(`USI_OFF_STATUS, 8'hc0);
    settle();
    pin(o_overflow_irq, 1'b1);
    w(`USI_OFF_STATUS, 8'h40);
    rd(`USI_OFF_STATUS, 8'h80);
    settle();
    pin(o_overflow_irq, 1'b0);
  endtask

  task automatic t_timer();
    w(`USI_OFF_STATUS, 8'hc0);
    w(`USI_OFF_CTRL, 8'h04);
    repeat (3) begin
      @(posedge i_core_clk);
      i_timer0_match <= 1'b1;
      @(posedge i_core_clk);
      i_timer0_match <= 1'b0;
    end
    rd(`USI_OFF_STATUS, 8'h83);
  endtask

  task automatic t_ext();
    w(`USI_OFF_STATUS, 8'hc0);
    w(`USI_OFF_CTRL, 8'h08);
    serial_peer_inst.send_byte(8'ha5);
    settle();
    rd(`USI_OFF_DATA, 8'ha5);
    rd(`USI_OFF_STATUS, 8'hc0);
  endtask

  task automatic t_toggle();
    w(`USI_OFF_STATUS, 8'hc0);
    w(`USI_OFF_CTRL, 8'h0b);
    rd(`USI_OFF_STATUS, 8'h81);
    rd(`USI_OFF_PORT, 8'h04);
    rd(`USI_OFF_CTRL, 8'h08);
  endtask

  task automatic t_pins();
    w(`USI_OFF_CTRL, 8'h00);
    w(`USI_OFF_PORT, 8'h12);
    w(`USI_OFF_DATA, 8'h80);
    settle();
    pin(o_do_pin_out, 1'b0);
    w(`USI_OFF_CTRL, 8'h10);
    settle();
    pin(o_do_pin_out, 1'b1);
    pin(o_do_pin_oe_n, 1'b0);
    pin(o_sda_pullup, 1'b1);
    w(`USI_OFF_PORT, 8'h32);
    w(`USI_OFF_DATA, 8'h00);
    w(`USI_OFF_CTRL, 8'h20);
    settle();
    pin(o_sda_pin_oe_n, 1'b0);
    pin(o_sda_pullup, 1'b0);
    w(`USI_OFF_DATA, 8'hff);
    settle();
    pin(o_sda_pin_oe_n, 1'b1);
    w(`USI_OFF_PORT, 8'h76);
    w(`USI_OFF_STATUS, 8'hcf);
    w(`USI_OFF_CTRL, 8'h32);
    settle();
    pin(o_clk_pin_oe_n, 1'b0);
    w(`USI_OFF_STATUS, 8'h40);
    settle();
    pin(o_clk_pin_oe_n, 1'b1);
  endtask

  task automatic t_start();
    w(`USI_OFF_CTRL, 8'h20);
    w(`USI_OFF_STATUS, 8'hc0);
    serial_peer_inst.start_cond();
    settle();
    pin(o_clk_pin_oe_n, 1'b0);
    w(`USI_OFF_STATUS, 8'h80);
    settle();
    pin(o_clk_pin_oe_n, 1'b1);
  endtask

  initial begin
    repeat (10) @(posedge i_core_clk);
    i_reset_n <= 1'b1;
    t_reset();
    t_count();
    t_ovf();
    t_timer();
    t_ext();
    t_toggle();
    t_pins();
    t_start();
    end_of_test();
  end
endmodule
